// ### core/rtg_pkg.sv
// shared constants, register map and types of the transmit guard and gear shaping block
package rtg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 40;
  localparam int GUARD_UNIT_NS  = 1000;
  localparam int GUARD_UNIT_CYC = (GUARD_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEAS_UNIT_NS   = 100000;
  localparam int MEAS_UNIT_CYC  = (MEAS_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W          = 12;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_GUARD = 8'h04;
  localparam logic [7:0] REG_DPC   = 8'h08;
  localparam logic [7:0] REG_THR   = 8'h0C;
  localparam logic [7:0] REG_TXCFG = 8'h10;
  localparam logic [7:0] REG_PROTO = 8'h14;
  localparam logic [7:0] REG_STAT  = 8'h18;
  localparam logic [7:0] REG_TXOUT = 8'h1C;
  localparam logic [7:0] REG_LUTSZ = 8'h20;
  localparam logic [1:0] LUT_PAGE  = 2'h1;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C_GO = 0, C_GRID = 1, C_FIELD = 2, C_MULTI = 3;
  localparam int C_DPC = 4, C_PAY = 5, C_PROT = 6, C_LOAD = 7;
  localparam int DPC_INT_LO = 0, DPC_NG_LO = 8, THR_MIN_LO = 0, THR_MAX_LO = 16;
  localparam int TX_CAR_LO = 0, TX_RISE_LO = 8, TX_FALL_LO = 12;
  localparam int TX_SCAR_LO = 16, TX_SCLK_LO = 24, TX_CLK_LO = 28;
  localparam int ST_BUSY = 8, ST_WALK = 9, ST_ARM = 10, ST_GO = 11;
  localparam int CAR_W = 5, TAU_W = 4, CLK_W = 3, GEAR_W = 4, MASK_W = 14;
  localparam int E_GEAR_LO = 0, E_FALL_LO = 4, E_RISE_LO = 8, E_CAR_LO = 12;
  localparam int E_MASK_LO = 16, DELTA_W = 4;
  // ----------------------------------------------------------------
  // reset values and states
  // ----------------------------------------------------------------
  localparam logic [3:0] NUM_GEARS_RST = 4'h1;
  localparam logic [7:0] MEAS_INT_RST  = 8'h0A;
  typedef enum logic [1:0] {
    WALK_IDLE = 2'b01,
    WALK_RUN  = 2'b10
  } rtg_walk_t;
endpackage

// ### core/rtg_smadd.sv
// saturating sign-magnitude adjuster for one shaping field
`timescale 1ns/1ps
module rtg_smadd #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] i_val,
  input  wire logic [3:0]   i_delta,
  output logic      [W-1:0] o_val
);
  logic [W:0] sum;
  logic [W:0] mag;

  if (W < 3) begin : g_chk
    $error("rtg_smadd: field narrower than the magnitude");
  end

  assign mag = (W + 1)'(i_delta[2:0]);
  assign sum = {1'b0, i_val} + mag;

  // clamps at both ends so repeated steps never wrap [R21]
  always_comb begin
    if (!i_delta[3]) begin
      o_val = sum[W] ? {W{1'b1}} : sum[W-1:0];
    end else if ({1'b0, i_val} < mag) begin
      o_val = '0;
    end else begin
      o_val = W'({1'b0, i_val} - mag);
    end
  end
endmodule

// ### core/rtg_guard.sv
// guard period counter started on reception end or field on
`timescale 1ns/1ps
module rtg_guard #(
  parameter int UNIT_CYC = rtg_pkg::GUARD_UNIT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_guard,
  output logic            o_busy,
  output logic            o_expire
);
  typedef struct packed {
    logic [rtg_pkg::PRE_W-1:0] pre;
    logic [7:0]                cnt;
    logic                      expire;
  } rtg_guard_st_t;

  localparam logic [rtg_pkg::PRE_W-1:0] PRE_TOP = rtg_pkg::PRE_W'(UNIT_CYC - 1);

  rtg_guard_st_t s;
  rtg_guard_st_t next_s;

  if (UNIT_CYC < 1 || UNIT_CYC > 4096) begin : g_chk
    $error("rtg_guard: unit count out of range");
  end

  always_comb begin
    next_s        = s;
    next_s.expire = 1'b0;
    if (i_start) begin
      // zero setting leaves the counter idle [R8]
      next_s.cnt = i_guard;
      next_s.pre = PRE_TOP;
    end else if (s.cnt != 8'h00) begin
      if (s.pre == '0) begin
        next_s.pre    = PRE_TOP;
        next_s.cnt    = s.cnt - 8'h01;
        next_s.expire = (s.cnt == 8'h01);
      end else begin
        next_s.pre = s.pre - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_busy   = (s.cnt != 8'h00);
  assign o_expire = s.expire;
endmodule

// ### core/rtg_top.sv
// transmit guard timing, power gear stepping and wave shaping adaption with AHB-Lite registers
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - no transmit start while guard period runs
// R2 - early go flag sends exactly at expiry
// R3 - late go with grid sync aligns grid
// R4 - guard starts at reception end
// R5 - no guard start on restart or multi-receive
// R6 - guard starts at field on when enabled
// R7 - only go flag or payload command send
// R8 - zero guard setting disables the guard
// R9 - shaping pattern uses its own clock, carrier
// R10 - agc sampled every configured measurement interval
// R11 - threshold crossing steps to another gear
// R12 - at most fifteen gears, application count
// R13 - table entries carry gear, ascending order
// R14 - entry holds mode mask and gear
// R15 - entry carrier change is sign magnitude
// R16 - entry edge changes are sign magnitude
// R17 - gear switch triggers matching table lookup
// R18 - protocol load command also triggers lookup
// R19 - changes relative to loaded base settings
// R20 - rising gears accumulate earlier entries' changes
// R21 - adjusted fields saturate, never wrap
// ----------------------------------------------------------------
module rtg_top #(
  parameter int AGC_W     = 10,
  parameter int LUT_DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic      [31:0]      o_hrdata,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  input  wire logic             i_rx_end,
  input  wire logic             i_rx_restart_dist,
  input  wire logic             i_field_on,
  input  wire logic             i_data_ready,
  input  wire logic             i_bit_grid,
  input  wire logic             i_shaping_active,
  input  wire logic [AGC_W-1:0] i_agc_level,
  output logic                  o_tx_start,
  output logic                  o_agc_sample,
  output logic      [3:0]       o_gear,
  output logic      [4:0]       o_tx_carrier,
  output logic      [3:0]       o_tx_rise,
  output logic      [3:0]       o_tx_fall,
  output logic      [2:0]       o_tx_clk_mode
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int         IW       = $clog2(LUT_DEPTH);
  localparam logic [4:0] DEPTH_L  = 5'(LUT_DEPTH);
  localparam logic [rtg_pkg::PRE_W-1:0] MEAS_TOP = rtg_pkg::PRE_W'(rtg_pkg::MEAS_UNIT_CYC - 1);

  typedef struct packed {
    logic                ph_act;
    logic                ph_wr;
    logic [7:0]          ph_addr;
    logic [31:0]         rdata;
    logic                go;
    logic                grid_sync;
    logic                from_field;
    logic                multi_rx;
    logic                dpc_en;
    logic [7:0]          guard_set;
    logic [7:0]          meas_int;
    logic [3:0]          num_gears;
    logic [AGC_W-1:0]    th_min;
    logic [AGC_W-1:0]    th_max;
    logic [31:0]         txcfg;
    logic [13:0]         proto;
    logic [4:0]          lut_size;
    logic                grid_arm;
    logic                tx_start;
    logic [rtg_pkg::PRE_W-1:0] pre_cnt;
    logic [7:0]          int_cnt;
    logic                agc_sample;
    logic [3:0]          gear;
    rtg_pkg::rtg_walk_t  st;
    logic [4:0]          idx;
    logic [4:0]          car;
    logic [3:0]          rise;
    logic [3:0]          fall;
    logic [4:0]          o_car;
    logic [3:0]          o_rise;
    logic [3:0]          o_fall;
    logic [2:0]          o_clk;
  } rtg_top_st_t;

  rtg_top_st_t s;
  rtg_top_st_t next_s;
  logic [31:0] lut [LUT_DEPTH];

  logic        bus_acc;
  logic        bus_wr;
  logic        lut_wr;
  logic        g_start;
  logic        g_busy;
  logic        g_expire;
  logic        start_ok;
  logic        tick;
  logic        gear_sw;
  logic        prot_cmd;
  logic        load_cmd;
  logic        walk_go;
  logic [3:0]  gmax;
  logic [31:0] ent;
  logic [31:0] rd_val;
  logic [4:0]  adj_car;
  logic [3:0]  adj_rise;
  logic [3:0]  adj_fall;

  if (LUT_DEPTH < 2 || LUT_DEPTH > 16 || AGC_W < 1 || AGC_W > 16) begin : g_chk
    $error("rtg_top: table depth or agc width out of range");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic lut_hit(input logic [7:0] a);
    return (a[7:6] == rtg_pkg::LUT_PAGE) && ({1'b0, a[5:2]} < DEPTH_L);
  endfunction

  // ----------------------------------------------------------------
  // bus slave: zero wait, always OKAY
  // ----------------------------------------------------------------
  assign bus_acc     = i_hsel && i_hready && i_htrans[1] && (i_hsize == 3'h2);
  assign bus_wr      = s.ph_act && s.ph_wr && i_hready;
  assign lut_wr      = bus_wr && lut_hit(s.ph_addr);
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = s.rdata;

  always_comb begin
    rd_val = '0;
    if (lut_hit(i_haddr[7:0])) begin
      rd_val = lut[i_haddr[IW+1:2]];
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_CTRL)) begin
      rd_val[rtg_pkg::C_GO]    = s.go;
      rd_val[rtg_pkg::C_GRID]  = s.grid_sync;
      rd_val[rtg_pkg::C_FIELD] = s.from_field;
      rd_val[rtg_pkg::C_MULTI] = s.multi_rx;
      rd_val[rtg_pkg::C_DPC]   = s.dpc_en;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_GUARD)) begin
      rd_val[7:0] = s.guard_set;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_DPC)) begin
      rd_val[rtg_pkg::DPC_INT_LO +: 8] = s.meas_int;
      rd_val[rtg_pkg::DPC_NG_LO +: 4]  = s.num_gears;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_THR)) begin
      rd_val[rtg_pkg::THR_MIN_LO +: AGC_W] = s.th_min;
      rd_val[rtg_pkg::THR_MAX_LO +: AGC_W] = s.th_max;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_TXCFG)) begin
      rd_val = s.txcfg;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_PROTO)) begin
      rd_val[13:0] = s.proto;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_STAT)) begin
      rd_val[3:0]              = s.gear;
      rd_val[rtg_pkg::ST_BUSY] = g_busy;
      rd_val[rtg_pkg::ST_WALK] = (s.st == rtg_pkg::WALK_RUN);
      rd_val[rtg_pkg::ST_ARM]  = s.grid_arm;
      rd_val[rtg_pkg::ST_GO]   = s.go;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_TXOUT)) begin
      rd_val[rtg_pkg::TX_CAR_LO +: rtg_pkg::CAR_W]  = s.o_car;
      rd_val[rtg_pkg::TX_RISE_LO +: rtg_pkg::TAU_W] = s.o_rise;
      rd_val[rtg_pkg::TX_FALL_LO +: rtg_pkg::TAU_W] = s.o_fall;
      rd_val[rtg_pkg::TX_CLK_LO +: rtg_pkg::CLK_W]  = s.o_clk;
    end else if (hit(i_haddr[7:0], rtg_pkg::REG_LUTSZ)) begin
      rd_val[4:0] = s.lut_size;
    end
  end

  // table memory: written by software, read one entry per walk step
  always_ff @(posedge i_clk) begin
    if (lut_wr) begin
      lut[s.ph_addr[IW+1:2]] <= i_hwdata;
    end
  end

  assign ent = ({1'b0, s.idx} < {1'b0, DEPTH_L}) ? lut[s.idx[IW-1:0]] : '0;

  // ----------------------------------------------------------------
  // guard timer
  // ----------------------------------------------------------------
  assign g_start = (i_rx_end && !i_rx_restart_dist && !s.multi_rx) // [R4] [R5]
                 || (i_field_on && s.from_field);                  // [R6]

  rtg_guard #(
    .UNIT_CYC (rtg_pkg::GUARD_UNIT_CYC)
  ) u_guard (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_start  (g_start),
    .i_guard  (s.guard_set),
    .o_busy   (g_busy),
    .o_expire (g_expire)
  );

  // held go flag fires in the very cycle the guard lapses [R1] [R2] [R3]
  assign start_ok = s.go && i_data_ready && !g_busy && (!s.grid_arm || i_bit_grid);

  // ----------------------------------------------------------------
  // shaping adjusters
  // ----------------------------------------------------------------
  rtg_smadd #(.W(rtg_pkg::CAR_W)) u_car (
    .i_val   (s.car),
    .i_delta (ent[rtg_pkg::E_CAR_LO +: rtg_pkg::DELTA_W]), // [R15]
    .o_val   (adj_car)
  );
  rtg_smadd #(.W(rtg_pkg::TAU_W)) u_rise (
    .i_val   (s.rise),
    .i_delta (ent[rtg_pkg::E_RISE_LO +: rtg_pkg::DELTA_W]), // [R16]
    .o_val   (adj_rise)
  );
  rtg_smadd #(.W(rtg_pkg::TAU_W)) u_fall (
    .i_val   (s.fall),
    .i_delta (ent[rtg_pkg::E_FALL_LO +: rtg_pkg::DELTA_W]), // [R16]
    .o_val   (adj_fall)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign tick = s.dpc_en && (s.pre_cnt == '0) && (s.int_cnt == 8'h00);
  assign gmax = (s.num_gears == 4'h0) ? 4'h0 : s.num_gears - 4'h1;

  always_comb begin
    next_s            = s;
    next_s.tx_start   = 1'b0;
    next_s.agc_sample = 1'b0;
    gear_sw           = 1'b0;
    prot_cmd          = 1'b0;
    load_cmd          = 1'b0;
    next_s.ph_act     = bus_acc;
    if (bus_acc) begin
      next_s.ph_wr   = i_hwrite;
      next_s.ph_addr = i_haddr[7:0];
      next_s.rdata   = i_hwrite ? 32'h0000_0000 : rd_val;
    end
    if (start_ok) begin
      next_s.tx_start = 1'b1; // [R7]
      next_s.go       = 1'b0;
      next_s.grid_arm = 1'b0;
    end
    if (g_expire && !s.go && s.grid_sync) begin
      next_s.grid_arm = 1'b1; // [R3]
    end
    if (g_start) begin
      next_s.grid_arm = 1'b0;
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_CTRL)) begin
      // software set wins over the hardware clear above
      next_s.go         = i_hwdata[rtg_pkg::C_GO] || i_hwdata[rtg_pkg::C_PAY]
                          || (s.go && !start_ok);
      next_s.grid_sync  = i_hwdata[rtg_pkg::C_GRID];
      next_s.from_field = i_hwdata[rtg_pkg::C_FIELD];
      next_s.multi_rx   = i_hwdata[rtg_pkg::C_MULTI];
      next_s.dpc_en     = i_hwdata[rtg_pkg::C_DPC];
      prot_cmd          = i_hwdata[rtg_pkg::C_PROT];
      load_cmd          = i_hwdata[rtg_pkg::C_LOAD];
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_GUARD)) begin
      next_s.guard_set = i_hwdata[7:0];
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_DPC)) begin
      next_s.meas_int  = i_hwdata[rtg_pkg::DPC_INT_LO +: 8];
      next_s.num_gears = i_hwdata[rtg_pkg::DPC_NG_LO +: 4];
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_THR)) begin
      next_s.th_min = i_hwdata[rtg_pkg::THR_MIN_LO +: AGC_W];
      next_s.th_max = i_hwdata[rtg_pkg::THR_MAX_LO +: AGC_W];
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_TXCFG)) begin
      next_s.txcfg = i_hwdata;
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_PROTO)) begin
      next_s.proto = i_hwdata[13:0];
    end
    if (bus_wr && hit(s.ph_addr, rtg_pkg::REG_LUTSZ)) begin
      next_s.lut_size = (i_hwdata[4:0] > DEPTH_L) ? DEPTH_L : i_hwdata[4:0];
    end
    // measurement interval: (byte + 1) prescaled units [R10]
    if (!s.dpc_en) begin
      next_s.pre_cnt = '0;
      next_s.int_cnt = 8'h00;
    end else if (s.pre_cnt == '0) begin
      next_s.pre_cnt = MEAS_TOP;
      next_s.int_cnt = (s.int_cnt == 8'h00) ? s.meas_int : s.int_cnt - 8'h01;
    end else begin
      next_s.pre_cnt = s.pre_cnt - 1'b1;
    end
    if (tick) begin
      next_s.agc_sample = 1'b1;
      if (i_agc_level > s.th_max && s.gear < gmax) begin
        next_s.gear = s.gear + 4'h1; // [R11] [R12]
        gear_sw     = 1'b1;
      end else if (i_agc_level < s.th_min && s.gear != 4'h0) begin
        next_s.gear = s.gear - 4'h1; // [R11]
        gear_sw     = 1'b1;
      end
    end
    // table walk: entries up to the current gear pile up [R20]
    case (s.st)
      rtg_pkg::WALK_IDLE: begin
      end
      rtg_pkg::WALK_RUN: begin
        // ascending gear order lets the walk stop at the first higher gear [R13]
        if (s.idx >= s.lut_size || ent[rtg_pkg::E_GEAR_LO +: rtg_pkg::GEAR_W] > s.gear) begin
          next_s.st = rtg_pkg::WALK_IDLE;
        end else begin
          if ((ent[rtg_pkg::E_MASK_LO +: rtg_pkg::MASK_W] & s.proto) != 14'h0000) begin // [R14]
            next_s.car  = adj_car;
            next_s.rise = adj_rise;
            next_s.fall = adj_fall;
          end
          next_s.idx = s.idx + 5'h01;
        end
      end
      default: begin
        next_s.st = rtg_pkg::WALK_IDLE;
      end
    endcase
    walk_go = gear_sw || prot_cmd; // [R17] [R18]
    if (walk_go || load_cmd) begin
      // every walk restarts from the loaded base [R19]
      next_s.car  = s.txcfg[rtg_pkg::TX_CAR_LO +: rtg_pkg::CAR_W];
      next_s.rise = s.txcfg[rtg_pkg::TX_RISE_LO +: rtg_pkg::TAU_W];
      next_s.fall = s.txcfg[rtg_pkg::TX_FALL_LO +: rtg_pkg::TAU_W];
      next_s.idx  = 5'h00;
      next_s.st   = walk_go ? rtg_pkg::WALK_RUN : rtg_pkg::WALK_IDLE;
    end
    // pattern period swaps in its own carrier and clock mode [R9]
    next_s.o_car  = i_shaping_active ? s.txcfg[rtg_pkg::TX_SCAR_LO +: rtg_pkg::CAR_W] : s.car;
    next_s.o_clk  = i_shaping_active ? s.txcfg[rtg_pkg::TX_SCLK_LO +: rtg_pkg::CLK_W]
                                     : s.txcfg[rtg_pkg::TX_CLK_LO +: rtg_pkg::CLK_W];
    next_s.o_rise = s.rise;
    next_s.o_fall = s.fall;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s           <= '0;
      s.st        <= rtg_pkg::WALK_IDLE;
      s.num_gears <= rtg_pkg::NUM_GEARS_RST;
      s.meas_int  <= rtg_pkg::MEAS_INT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign o_tx_start    = s.tx_start;
  assign o_agc_sample  = s.agc_sample;
  assign o_gear        = s.gear;
  assign o_tx_carrier  = s.o_car;
  assign o_tx_rise     = s.o_rise;
  assign o_tx_fall     = s.o_fall;
  assign o_tx_clk_mode = s.o_clk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_guard_hold: assert property ($past(g_busy) |-> !o_tx_start) // [R1]
    else $error("transmit started inside guard period");
  a_exact_time: assert property ( // [R2]
    g_expire && s.go && i_data_ready && !s.grid_arm |=> o_tx_start)
    else $error("held go flag did not send at guard expiry");
  a_grid_align: assert property (o_tx_start && $past(s.grid_arm) |-> $past(i_bit_grid)) // [R3]
    else $error("armed start missed the bit grid");
  a_rx_guard: assert property ( // [R4]
    i_rx_end && !i_rx_restart_dist && !s.multi_rx && s.guard_set != 8'h00 |=> g_busy)
    else $error("reception end did not start guard");
  a_guard_cause: assert property ($rose(g_busy) |-> $past(g_start)) // [R5]
    else $error("guard started without a valid cause");
  a_field_guard: assert property ( // [R6]
    i_field_on && s.from_field && s.guard_set != 8'h00 |=> g_busy)
    else $error("field on did not start guard");
  a_start_cause: assert property (o_tx_start |-> $past(s.go) && !s.go) // [R7]
    else $error("transmit start without go flag");
  a_guard_zero: assert property ($rose(g_busy) |-> $past(s.guard_set) != 8'h00) // [R8]
    else $error("zero guard setting ran the counter");
  a_shape_carrier: assert property ( // [R9]
    i_shaping_active |=> o_tx_carrier == $past(s.txcfg[rtg_pkg::TX_SCAR_LO +: rtg_pkg::CAR_W]))
    else $error("pattern period carrier not selected");
  a_gear_step: assert property ( // [R17]
    $changed(s.gear) |-> $past(tick) && s.st == rtg_pkg::WALK_RUN && s.idx == 5'h00)
    else $error("gear changed without sample or lookup");
  a_gear_cap: assert property (o_gear != 4'hF) // [R12]
    else $error("gear beyond fifteen configurations");

  c_exact_send: cover property (g_expire ##1 o_tx_start);
  c_grid_send: cover property (s.grid_arm ##1 o_tx_start);
  c_gear_up: cover property (tick ##1 $changed(s.gear));
  c_walk_done: cover property (s.st == rtg_pkg::WALK_RUN ##1 s.st == rtg_pkg::WALK_IDLE);
endmodule

// ### testbench/rtg_rf_model.sv
// RF side model: reception ends, field switch-on, bit grid and AGC level
`timescale 1ns/1ps
module rtg_rf_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_kind,
  input  wire logic [9:0] i_load,
  output logic            o_rx_end,
  output logic            o_restart,
  output logic            o_field_on,
  output logic            o_bit_grid,
  output logic [9:0]      o_agc
);
  logic [3:0] ph;
  initial begin
    {ph, o_rx_end, o_restart, o_field_on, o_bit_grid} = 8'h00;
    o_agc = 10'h000;
  end
  // kind 1 ends a frame, 3 ends it after a disturbance, 2 switches the field on
  always @(posedge i_clk) begin
    ph         <= ph + 4'h1;
    o_bit_grid <= (ph == 4'hF);
    o_rx_end   <= i_kind[0];
    o_restart  <= i_kind == 2'h3;
    o_field_on <= i_kind == 2'h2;
    o_agc      <= i_load;
  end
endmodule

// ### testbench/rtg_top_bench.sv
// self-checking bench for the transmit guard and gear shaping block
`timescale 1ns/1ps
module rtg_top_bench;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, rdy = 1'b0, shp = 1'b0;
  logic [1:0]  htrans = 2'h0, kind = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [9:0]  load = 10'h0, agc;
  logic        hro, hresp, rx_end, rst_d, fon, grid, tx, smp;
  logic [3:0]  gear, rise, fall;
  logic [4:0]  car;
  logic [2:0]  cmode;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, gcyc = 0, ntx = 0, i;
  logic [7:0]  cc [4] = '{8'h01, 8'h01, 8'h09, 8'h05};
  logic [1:0]  ks [4] = '{2'h1, 2'h3, 2'h1, 2'h2};
  int          lo [4] = '{24, 0, 0, 24};
  int          hi [4] = '{30, 4, 4, 30};
  logic [31:0] lut [3] = '{32'h0001_2300, 32'h0001_19A1, 32'h0002_0012};

  initial forever #20 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    if (grid === 1'b1) gcyc <= cyc;
    if (tx === 1'b1) ntx <= ntx + 1;
  end

  rtg_top rtg_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hro),
    .o_hrdata(hrdata), .o_hreadyout(hro), .o_hresp(hresp), .i_rx_end(rx_end),
    .i_rx_restart_dist(rst_d), .i_field_on(fon), .i_data_ready(rdy), .i_bit_grid(grid),
    .i_shaping_active(shp), .i_agc_level(agc), .o_tx_start(tx), .o_agc_sample(smp),
    .o_gear(gear), .o_tx_carrier(car), .o_tx_rise(rise), .o_tx_fall(fall),
    .o_tx_clk_mode(cmode));
  rtg_rf_model rtg_rf_model_inst (.i_clk(i_clk), .i_kind(kind), .i_load(load),
    .o_rx_end(rx_end), .o_restart(rst_d), .o_field_on(fon), .o_bit_grid(grid), .o_agc(agc));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task stop_test;
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // bounded wait for hready at a rising edge
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hro !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      stop_test;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wait_tx(input int l, input int h);
    int n;
    for (n = 0; n <= h && tx !== 1'b1; n++) @(negedge i_clk);
    chk({31'h0, n >= l && n <= h}, 32'h1);
  endtask
  task wait_gear(input logic [3:0] g);
    int n;
    for (n = 0; n < 6000 && gear !== g; n++) @(negedge i_clk);
    chk({28'h0, gear}, {28'h0, g});
    chk({31'h0, smp}, 32'h1);
  endtask
  task shape(input logic [15:0] e);
    tick(6);
    chk({16'h0, cmode, fall, rise, car}, {16'h0, e});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    i_rst <= 1'b0;
    rdchk(rtg_pkg::REG_DPC, 32'h0000_010A);
    rdchk(8'h30, 32'h0);
    wr(rtg_pkg::REG_GUARD, 32'h1);
    for (i = 0; i < 4; i++) begin
      rdy <= 1'b0;
      wr(rtg_pkg::REG_CTRL, {24'h0, cc[i]});
      @(posedge i_clk);
      kind <= ks[i];
      @(posedge i_clk);
      kind <= 2'h0;
      // data ready only once any guard has started, so a held go must wait it out
      tick(2);
      rdy  <= 1'b1;
      wait_tx(lo[i], hi[i]);
      tick(30);
    end
    wr(rtg_pkg::REG_GUARD, 32'h0);
    wr(rtg_pkg::REG_CTRL, 32'h20);
    wait_tx(0, 4);
    wr(rtg_pkg::REG_GUARD, 32'h1);
    wr(rtg_pkg::REG_CTRL, 32'h2);
    kind <= 2'h1;
    @(posedge i_clk);
    kind <= 2'h0;
    tick(35);
    rdchk(rtg_pkg::REG_STAT, 32'h400);
    chk(ntx, 5);
    wr(rtg_pkg::REG_CTRL, 32'h3);
    wait_tx(0, 20);
    chk({31'h0, cyc - gcyc <= 3}, 32'h1);
    wr(rtg_pkg::REG_THR, 32'h00C8_0064);
    wr(rtg_pkg::REG_DPC, 32'h0000_0300);
    wr(rtg_pkg::REG_TXCFG, 32'h2503_7E0A);
    wr(rtg_pkg::REG_PROTO, 32'h1);
    wr(rtg_pkg::REG_LUTSZ, 32'h3);
    for (i = 0; i < 3; i++) wr(8'(8'h40 + 4 * i), lut[i]);
    wr(rtg_pkg::REG_CTRL, 32'h80);
    shape({3'h2, 4'h7, 4'hE, 5'h0A});
    wr(rtg_pkg::REG_CTRL, 32'h40);
    shape({3'h2, 4'h7, 4'hF, 5'h0C});
    load <= 10'd300;
    wr(rtg_pkg::REG_CTRL, 32'h10);
    wait_gear(4'h1);
    shape({3'h2, 4'h5, 4'hE, 5'h0D});
    wait_gear(4'h2);
    tick(5200);
    chk({28'h0, gear}, 32'h2);
    wr(rtg_pkg::REG_PROTO, 32'h2);
    wr(rtg_pkg::REG_CTRL, 32'h50);
    shape({3'h2, 4'h8, 4'hE, 5'h0A});
    shp <= 1'b1;
    shape({3'h5, 4'h8, 4'hE, 5'h03});
    load <= 10'd50;
    wait_gear(4'h1);
    stop_test;
  end
endmodule
